// ===== stepper_pkg.sv
// shared constants and types for the stepper phase sequencer link
package stepper_pkg;

   // clock and timing
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned T_SETTLE_NS     = 7000;
   localparam int unsigned T_WIDTH_ONE_NS  = 10000;
   localparam int unsigned T_WIDTH_BOTH_NS = 20000;
   localparam int unsigned F_MAX_ONE_HZ    = 50000;
   localparam int unsigned F_MAX_BOTH_HZ   = 20000;
   localparam int unsigned T_INIT_GAP_NS   = 10000;
   localparam int unsigned T_INIT_PULSE_NS = 1000;

   localparam int unsigned T_HALF_ONE_NS  = 1000000000 / (2 * F_MAX_ONE_HZ);
   localparam int unsigned T_HALF_BOTH_NS = 1000000000 / (2 * F_MAX_BOTH_HZ);
   localparam int unsigned T_EDGE_ONE_NS  =
      (T_HALF_ONE_NS > T_WIDTH_ONE_NS) ? T_HALF_ONE_NS : T_WIDTH_ONE_NS;
   localparam int unsigned T_EDGE_BOTH_NS =
      (T_HALF_BOTH_NS > T_WIDTH_BOTH_NS) ? T_HALF_BOTH_NS : T_WIDTH_BOTH_NS;

   // least times round up to whole cycles
   localparam int unsigned SETTLE_CYC    = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EDGE_ONE_CYC  = (T_EDGE_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EDGE_BOTH_CYC = (T_EDGE_BOTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned INIT_GAP_CYC  = (T_INIT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned INIT_PULSE_CYC = (T_INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 12;

   // phase position on a 16-slot electrical cycle
   localparam int unsigned PHASE_W     = 4;
   localparam logic [3:0]  PHASE_RESET = 4'h2;
   // step size per excitation select {b,a}, one nibble each, select 0 in the low nibble
   localparam logic [15:0] MODE_STEP_MAP = 16'h1124;
   // drive pattern {bb,ab,b,a} per octant, octant 0 in the low nibble
   localparam logic [31:0] DRIVE_TABLE = 32'h98C46231;

   // fault kind codes on the fault kind lines
   localparam logic [1:0] FK_NONE        = 2'h0;
   localparam logic [1:0] FK_OPEN        = 2'h1;
   localparam logic [1:0] FK_OVERCURRENT = 2'h2;
   localparam logic [1:0] FK_OVERHEAT    = 2'h3;

   typedef enum logic [2:0] {
      H_INIT,
      H_GAP,
      H_IDLE,
      H_SETTLE,
      H_EDGE,
      H_WIDTH
   } host_state_type;

endpackage : stepper_pkg

// ===== stepper_link_if.sv
// pin-level link between controller and stepper sequencer
`timescale 1ns/1ps
interface stepper_link_if;
   logic       step_clk;
   logic       rotation_direction_select;
   logic       excitation_select_a;
   logic       excitation_select_b;
   logic       edge_select;
   logic       enable;
   logic       system_init_low;
   logic       fault_any_out;
   logic       fault_any_oe;
   logic       fault_any_low;
   logic [1:0] fault_kind_level;
   logic       excitation_monitor_out;

   // open-drain line with pull-up
   assign fault_any_low = fault_any_oe ? fault_any_out : 1'b1;

   modport device_end (
      input  step_clk,
      input  rotation_direction_select,
      input  excitation_select_a,
      input  excitation_select_b,
      input  edge_select,
      input  enable,
      input  system_init_low,
      output fault_any_out,
      output fault_any_oe,
      output fault_kind_level,
      output excitation_monitor_out
   );

   modport host_end (
      output step_clk,
      output rotation_direction_select,
      output excitation_select_a,
      output excitation_select_b,
      output edge_select,
      output enable,
      output system_init_low,
      input  fault_any_low,
      input  fault_kind_level,
      input  excitation_monitor_out
   );
endinterface : stepper_link_if

// ===== pin_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule : pin_sync

// ===== stepper_device_end.sv
// device end: phase sequencer, drive gating and fault latch
`timescale 1ns/1ps

// Overview of operation
// - edge select high: step on rising edges
// - edge select low: step on both edges
// - direction low clockwise, high counterclockwise
// - controller holds direction 7 us around edges
// - controller holds mode selects 7 us around edges
// - enable low forces all drive outputs off
// - enable low freezes state, ignores inputs except the reset pin
// - power-on reset or reset pin initialises
// - controller keeps enable low on low supply
// - controller waits 10 us after reset
// - controller limits step clock 20/50 kHz
// - controller keeps pulses 20/10 us wide
// - open-drain fault line low on fault
// - fault kind reported with three levels
// - faults latch and keep drive off
// - faults clear only by reset
// - monitor toggles per cycle, mode dependent rate
// - controller decelerates gradually before stopping; the host end leaves this to the user
module stepper_device_end
   import stepper_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               arst_n,
   stepper_link_if.device_end      link,
   input  wire logic               open_detect,
   input  wire logic               overcurrent_detect,
   input  wire logic               overheat_detect,
   output logic [3:0]              phase_drive,
   output logic [PHASE_W-1:0]      phase_index,
   output logic                    fault_latched,
   output logic [1:0]              fault_kind
);

   // step size for an excitation select
   function automatic logic [PHASE_W-1:0] mode_step(input logic [1:0] sel);
      mode_step = MODE_STEP_MAP[{sel, 2'b00} +: 4];
   endfunction : mode_step

   // drive pattern for a phase position
   function automatic logic [3:0] drive_pattern(input logic [PHASE_W-1:0] idx);
      drive_pattern = DRIVE_TABLE[{idx[3:1], 2'b00} +: 4];
   endfunction : drive_pattern

   // synchronised pin levels
   logic [6:0] pins_s;
   logic [2:0] det_s;
   logic       step_s;
   logic       dir_s;
   logic       sel_a_s;
   logic       sel_b_s;
   logic       edge_s;
   logic       run_s;
   logic       init_low_s;

   // state
   logic               step_prev_ff;
   logic [PHASE_W-1:0] phase_ff;
   logic [PHASE_W-1:0] nxt_phase;
   logic               monitor_ff;
   logic               fault_ff;
   logic [1:0]         kind_ff;
   logic [1:0]         nxt_kind;
   logic [3:0]         drive_ff;

   // decoded events
   logic               rise;
   logic               fall;
   logic               step_take;
   logic               init_hold;
   logic               wrap;
   logic [PHASE_W-1:0] delta;

   pin_sync #(
      .W (7)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .d       ({link.step_clk,
                 link.rotation_direction_select,
                 link.excitation_select_a,
                 link.excitation_select_b,
                 link.edge_select,
                 link.enable,
                 link.system_init_low}),
      .q       (pins_s)
   );

   pin_sync #(
      .W (3)
   ) u_det_sync (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .d       ({open_detect, overcurrent_detect, overheat_detect}),
      .q       (det_s)
   );

   assign step_s     = pins_s[6];
   assign dir_s      = pins_s[5];
   assign sel_a_s    = pins_s[4];
   assign sel_b_s    = pins_s[3];
   assign edge_s     = pins_s[2];
   assign run_s      = pins_s[1];
   assign init_low_s = pins_s[0];

   // reset hold comes from the synchronised reset pin alone; the power-on reset (arst_n) clears the flops directly
   assign init_hold = ~init_low_s;

   // edge detection on the step clock
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         step_prev_ff <= 1'b0;
      end else begin
         step_prev_ff <= step_s;
      end
   end

   assign rise = step_s & ~step_prev_ff;
   assign fall = ~step_s & step_prev_ff;

   // a step is accepted only while running, unfaulted and out of reset
   always_comb begin
      step_take = 1'b0;
      if (run_s && !fault_ff && !init_hold) begin
         if (edge_s) begin
            step_take = rise;
         end else begin
            step_take = rise | fall;
         end
      end
   end

   // next phase position, modulo the table length by natural wrap
   always_comb begin
      delta = mode_step({sel_b_s, sel_a_s});
      if (dir_s) begin
         nxt_phase = phase_ff - delta;
         wrap      = (nxt_phase > phase_ff);
      end else begin
         nxt_phase = phase_ff + delta;
         wrap      = (nxt_phase < phase_ff);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_ff <= PHASE_RESET;
      end else if (init_hold) begin
         phase_ff <= PHASE_RESET;
      end else if (step_take) begin
         phase_ff <= nxt_phase;
      end
   end

   // monitor toggles once per electrical cycle; rate follows the step size
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         monitor_ff <= 1'b0;
      end else if (init_hold) begin
         monitor_ff <= 1'b0;
      end else if (step_take && wrap) begin
         monitor_ff <= ~monitor_ff;
      end
   end

   // fault kind priority when several detectors fire together
   always_comb begin
      if (det_s[0]) begin
         nxt_kind = FK_OVERHEAT;
      end else if (det_s[1]) begin
         nxt_kind = FK_OVERCURRENT;
      end else begin
         nxt_kind = FK_OPEN;
      end
   end

   // latched fault; the condition going away does not release it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_ff <= 1'b0;
         kind_ff  <= FK_NONE;
      end else if (init_hold) begin
         fault_ff <= 1'b0;
         kind_ff  <= FK_NONE;
      end else if (run_s && !fault_ff && (|det_s)) begin
         fault_ff <= 1'b1;
         kind_ff  <= nxt_kind;
      end
   end

   // drive outputs off while disabled, faulted or in reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_ff <= 4'h0;
      end else if (!run_s || fault_ff || init_hold) begin
         drive_ff <= 4'h0;
      end else begin
         drive_ff <= drive_pattern(phase_ff);
      end
   end

   assign phase_drive   = drive_ff;
   assign phase_index   = phase_ff;
   assign fault_latched = fault_ff;
   assign fault_kind    = kind_ff;

   // open-drain fault line: pull low only while a fault is latched
   assign link.fault_any_out          = 1'b0;
   assign link.fault_any_oe           = fault_ff;
   assign link.fault_kind_level       = kind_ff;
   assign link.excitation_monitor_out = monitor_ff;

endmodule : stepper_device_end

// ===== stepper_host_end.sv
// host end: paces step clock and control levels toward the sequencer
`timescale 1ns/1ps
module stepper_host_end
   import stepper_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   stepper_link_if.host_end   link,
   input  wire logic          step_req,
   input  wire logic          step_ccw,
   input  wire logic [1:0]    mode_sel,
   input  wire logic          both_edges,
   input  wire logic          drive_enable,
   input  wire logic          supply_ok,
   input  wire logic          init_req,
   output logic               busy,
   output logic               fault_seen,
   output logic [1:0]         fault_kind
);

   host_state_type state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             clk_ff;
   logic             dir_ff;
   logic [1:0]       mode_ff;
   logic             edge_one_ff;
   logic             init_low_ff;
   logic             enable_ff;
   logic [1:0]       kind_ff;
   logic [3:0]       in_s;
   logic             cnt_done;

   pin_sync #(
      .W (4)
   ) u_in_sync (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .d       ({supply_ok, link.fault_any_low, link.fault_kind_level}),
      .q       (in_s)
   );

   assign cnt_done = (cnt_ff == '0);

   // sequencing; when to request steps, and deceleration, are up to the user
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff    <= H_INIT;
         cnt_ff      <= CNT_W'(INIT_PULSE_CYC - 1);
         clk_ff      <= 1'b0;
         dir_ff      <= 1'b0;
         mode_ff     <= 2'h0;
         edge_one_ff <= 1'b1;
         init_low_ff <= 1'b0;
      end else begin
         if (!cnt_done) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
         case (state_ff)
            H_INIT: begin
               init_low_ff <= 1'b0;
               clk_ff      <= 1'b0;
               if (cnt_done) begin
                  init_low_ff <= 1'b1;
                  cnt_ff      <= CNT_W'(INIT_GAP_CYC - 1);
                  state_ff    <= H_GAP;
               end
            end
            H_GAP: begin
               if (cnt_done) begin
                  state_ff <= H_IDLE;
               end
            end
            H_IDLE: begin
               if (init_req) begin
                  cnt_ff   <= CNT_W'(INIT_PULSE_CYC - 1);
                  state_ff <= H_INIT;
               end else if (step_req) begin
                  dir_ff      <= step_ccw;
                  mode_ff     <= mode_sel;
                  edge_one_ff <= ~both_edges;
                  cnt_ff      <= CNT_W'(SETTLE_CYC - 1);
                  state_ff    <= H_SETTLE;
               end
            end
            H_SETTLE: begin
               if (cnt_done) begin
                  state_ff <= H_EDGE;
               end
            end
            H_EDGE: begin
               clk_ff <= ~clk_ff;
               if (edge_one_ff) begin
                  cnt_ff <= CNT_W'(EDGE_ONE_CYC - 1);
               end else begin
                  cnt_ff <= CNT_W'(EDGE_BOTH_CYC - 1);
               end
               state_ff <= H_WIDTH;
            end
            H_WIDTH: begin
               if (cnt_done) begin
                  if (edge_one_ff && clk_ff) begin
                     state_ff <= H_EDGE;
                  end else begin
                     state_ff <= H_IDLE;
                  end
               end
            end
            default: begin
               state_ff <= H_IDLE;
            end
         endcase
      end
   end

   // enable held low while the supply is not good
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_ff <= 1'b0;
      end else begin
         enable_ff <= drive_enable & in_s[3];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         kind_ff <= FK_NONE;
      end else begin
         kind_ff <= in_s[1:0];
      end
   end

   assign busy       = (state_ff != H_IDLE);
   assign fault_seen = ~in_s[2];
   assign fault_kind = kind_ff;

   assign link.step_clk                  = clk_ff;
   assign link.rotation_direction_select = dir_ff;
   assign link.excitation_select_a       = mode_ff[0];
   assign link.excitation_select_b       = mode_ff[1];
   assign link.edge_select               = edge_one_ff;
   assign link.enable                    = enable_ff;
   assign link.system_init_low           = init_low_ff;

endmodule : stepper_host_end

// ===== stepper_link_checker.sv
// assertions on the link between controller end and sequencer end
`timescale 1ns/1ps
module stepper_link_checker
   import stepper_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic       step_clk,
   input  wire logic       rotation_direction_select,
   input  wire logic       excitation_select_a,
   input  wire logic       excitation_select_b,
   input  wire logic       edge_select,
   input  wire logic       enable,
   input  wire logic       system_init_low,
   input  wire logic       fault_any_oe,
   input  wire logic       fault_any_low,
   input  wire logic [1:0] fault_kind_level,
   input  wire logic       excitation_monitor_out
);
   logic [3:0]       ctl;
   logic [3:0]       ctl_ff;
   logic             clk_ff;
   logic             init_ff;
   logic [CNT_W-1:0] clk_age_ff;
   logic [CNT_W-1:0] ctl_age_ff;
   logic [CNT_W-1:0] init_age_ff;
   logic [CNT_W-1:0] rise_age_ff;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   assign ctl = {rotation_direction_select, excitation_select_b, excitation_select_a, edge_select};

   // saturating ages: since last step clock change, control change, reset pin release,
   // step clock rise
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_ff      <= 1'b0;
         ctl_ff      <= 4'h0;
         init_ff     <= 1'b0;
         clk_age_ff  <= '1;
         ctl_age_ff  <= '1;
         init_age_ff <= '1;
         rise_age_ff <= '1;
      end else begin
         clk_ff      <= step_clk;
         ctl_ff      <= ctl;
         init_ff     <= system_init_low;
         clk_age_ff  <= (step_clk != clk_ff) ? '0 : clk_age_ff + (clk_age_ff != '1);
         ctl_age_ff  <= (ctl != ctl_ff) ? '0 : ctl_age_ff + (ctl_age_ff != '1);
         init_age_ff <= (system_init_low && !init_ff) ? '0 : init_age_ff + (init_age_ff != '1);
         rise_age_ff <= (step_clk && !clk_ff) ? '0 : rise_age_ff + (rise_age_ff != '1);
      end
   end

   pulse_width_a: assert property ((step_clk != clk_ff) |-> clk_age_ff >= EDGE_ONE_CYC - 1)
      else $error("step clock level shorter than least width");
   ctl_setup_a: assert property ((step_clk != clk_ff) |-> ctl_age_ff >= SETTLE_CYC - 1)
      else $error("control level changed too close before a step edge");
   ctl_hold_a: assert property ((ctl != ctl_ff) |-> clk_age_ff >= SETTLE_CYC - 1)
      else $error("control level changed too close after a step edge");
   init_gap_a: assert property ((step_clk != clk_ff) |-> init_age_ff >= INIT_GAP_CYC - 1)
      else $error("step edge too soon after reset pin release");
   step_rate_a: assert property ((step_clk && !clk_ff) |-> rise_age_ff >= 2 * EDGE_ONE_CYC - 1)
      else $error("step clock rises faster than the highest step rate");
   fault_code_a: assert property (fault_any_oe |-> fault_kind_level != FK_NONE && !fault_any_low)
      else $error("fault line or kind wrong while fault latched");
   fault_hold_a: assert property (fault_any_oe && system_init_low |=> fault_any_oe && $stable(fault_kind_level))
      else $error("latched fault dropped or kind changed without reset");
   fault_clear_a: assert property (!system_init_low [*5] |-> !fault_any_oe && fault_kind_level == FK_NONE && !excitation_monitor_out)
      else $error("reset pin did not clear fault and monitor");
   frozen_mon_a: assert property ((!enable && system_init_low) [*4] |=> $stable(excitation_monitor_out))
      else $error("monitor moved while disabled");
   quiet_mon_a: assert property ((system_init_low && $stable(step_clk)) [*6] |=> $stable(excitation_monitor_out))
      else $error("monitor moved without a step edge");
endmodule : stepper_link_checker

// ===== stepper_phase_sequencer_tb.sv
// self-checking bench: controller end and sequencer end joined over the link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module stepper_phase_sequencer_tb
   import stepper_pkg::*;
   ;
   logic       ref_clk, arst_n, step_req, step_ccw, both_edges, drive_enable, supply_ok;
   logic       init_req, busy, fault_seen, fault_latched;
   logic       open_detect, overcurrent_detect, overheat_detect, exp_mon, exp_clk;
   logic [1:0] mode_sel, dev_kind, host_kind;
   logic [3:0] phase_drive, phase_index, exp_idx;
   logic [2:0] dets [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
   logic [1:0] kinds [4] = '{FK_OPEN, FK_OVERCURRENT, FK_OVERHEAT, FK_OVERHEAT};
   int         n_mismatch, checks_done, seed, i, k, r;

   stepper_link_if link_i ();
   stepper_device_end stepper_device_end_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .link(link_i.device_end),
      .open_detect(open_detect), .overcurrent_detect(overcurrent_detect),
      .overheat_detect(overheat_detect), .phase_drive(phase_drive),
      .phase_index(phase_index), .fault_latched(fault_latched), .fault_kind(dev_kind));
   stepper_host_end stepper_host_end_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .link(link_i.host_end), .step_req(step_req),
      .step_ccw(step_ccw), .mode_sel(mode_sel), .both_edges(both_edges),
      .drive_enable(drive_enable), .supply_ok(supply_ok), .init_req(init_req),
      .busy(busy), .fault_seen(fault_seen), .fault_kind(host_kind));
   stepper_link_checker stepper_link_checker_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .step_clk(link_i.step_clk),
      .rotation_direction_select(link_i.rotation_direction_select),
      .excitation_select_a(link_i.excitation_select_a),
      .excitation_select_b(link_i.excitation_select_b), .edge_select(link_i.edge_select),
      .enable(link_i.enable), .system_init_low(link_i.system_init_low),
      .fault_any_oe(link_i.fault_any_oe), .fault_any_low(link_i.fault_any_low),
      .fault_kind_level(link_i.fault_kind_level),
      .excitation_monitor_out(link_i.excitation_monitor_out));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic logic [3:0] drv(input logic [3:0] idx);
      logic [3:0] t [8];
      t = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};
      return t[idx[3:1]];
   endfunction : drv

   function automatic logic [3:0] stp(input logic [1:0] m);
      return (m == 2'h0) ? 4'h4 : (m == 2'h1) ? 4'h2 : 4'h1;
   endfunction : stp

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic wait_idle();
      for (int n = 0; n < 6000; n++) begin
         @(negedge ref_clk);
         if (busy === 1'b0) return;
      end
      n_mismatch++;
      $display("[ERR] busy exp 0 got 1");
      complete_run();
   endtask : wait_idle

   // one request gives at most one step; live low means the sequencer must not move
   task automatic do_step(input logic [1:0] m, input logic ccw, input logic both,
                          input logic live);
      logic [3:0] nxt;
      logic       moved;
      @(posedge ref_clk);
      mode_sel   <= m;
      step_ccw   <= ccw;
      both_edges <= both;
      step_req   <= 1'b1;
      @(posedge ref_clk);
      step_req <= 1'b0;
      wait_idle();
      // single edge from a high step clock only gives the ignored falling edge
      moved   = live && (both || !exp_clk);
      exp_clk = both ? ~exp_clk : 1'b0;
      nxt = ccw ? exp_idx - stp(m) : exp_idx + stp(m);
      if (moved && (ccw ? (nxt > exp_idx) : (nxt < exp_idx))) exp_mon = ~exp_mon;
      if (moved) exp_idx = nxt;
      `CHK("step_clk", exp_clk, link_i.step_clk)
      `CHK("phase_index", exp_idx, phase_index)
      `CHK("monitor", exp_mon, link_i.excitation_monitor_out)
      `CHK("phase_drive", live ? drv(exp_idx) : 4'h0, phase_drive)
   endtask : do_step

   task automatic chk_reset(input string nm);
      wait_idle();
      exp_idx = PHASE_RESET;
      exp_mon = 1'b0;
      exp_clk = 1'b0;
      `CHK("step_clk", exp_clk, link_i.step_clk)
      `CHK("phase_index", exp_idx, phase_index)
      `CHK("phase_drive", drv(exp_idx), phase_drive)
      `CHK("monitor", exp_mon, link_i.excitation_monitor_out)
      `CHK("fault_latched", 1'b0, fault_latched)
      `CHK("fault_line", 1'b1, link_i.fault_any_low)
      $display("test %s done", nm);
   endtask : chk_reset

   task automatic do_init();
      @(posedge ref_clk);
      init_req <= 1'b1;
      @(posedge ref_clk);
      init_req <= 1'b0;
      chk_reset("reset pin");
   endtask : do_init

   initial begin
      n_mismatch = 0;
      checks_done = 0;
      seed = 32'hA574;
      arst_n = 1'b0;
      {step_req, step_ccw, both_edges, init_req, mode_sel} = '0;
      {open_detect, overcurrent_detect, overheat_detect} = 3'h0;
      drive_enable = 1'b1;
      supply_ok = 1'b1;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk_reset("power-on");
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         do_step(i < 4 ? i[1:0] : r[1:0], i < 4 ? i[0] : r[2], i < 4 ? i[1] : r[3], 1'b1);
      end
      $display("test stepping done");
      @(posedge ref_clk);
      drive_enable <= 1'b0;
      repeat (6) @(posedge ref_clk);
      `CHK("enable", 1'b0, link_i.enable)
      `CHK("phase_drive", 4'h0, phase_drive)
      do_step(2'h3, 1'b0, 1'b0, 1'b0);
      @(posedge ref_clk);
      drive_enable <= 1'b1;
      repeat (6) @(posedge ref_clk);
      `CHK("phase_drive", drv(exp_idx), phase_drive)
      supply_ok <= 1'b0;
      repeat (6) @(posedge ref_clk);
      `CHK("enable", 1'b0, link_i.enable)
      supply_ok <= 1'b1;
      repeat (6) @(posedge ref_clk);
      `CHK("enable", 1'b1, link_i.enable)
      $display("test enable done");
      for (k = 0; k < 4; k++) begin
         @(posedge ref_clk);
         {overheat_detect, overcurrent_detect, open_detect} <= dets[k];
         repeat (5) @(posedge ref_clk);
         {overheat_detect, overcurrent_detect, open_detect} <= 3'h0;
         repeat (10) @(posedge ref_clk);
         `CHK("fault_kind", kinds[k], dev_kind)
         `CHK("host_kind", kinds[k], host_kind)
         `CHK("fault_line", 1'b0, link_i.fault_any_low)
         `CHK("fault_seen", 1'b1, fault_seen)
         r = $random(seed);
         do_step(r[1:0], r[2], r[3], 1'b0);
         `CHK("fault_latched", 1'b1, fault_latched)
         do_init();
      end
      do_step(2'h0, 1'b0, 1'b0, 1'b1);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk_reset("mid-run reset");
      complete_run();
   end
endmodule : stepper_phase_sequencer_tb
